// ===== iq_phase_correction_output_delay_test.sv
/*
 * Self-checking bench for iqpc_top: register table, delay line, commit.
 * Assumes iqpc_pkg and iqpc_chk are compiled first.
 */
`timescale 1ns/1ns
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_fail++; \
   $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module iq_phase_correction_output_delay_test;
   import iqpc_pkg::*;
   typedef struct {bit w; logic [7:0] a; logic [31:0] d; logic [1:0] r;} iqpc_row_t;
   logic aclk, aresetn = 1'b0, ce = 1'b1;
   logic awv = 1'b0, wv = 1'b0, brdy = 1'b0, arv = 1'b0, rrdy = 1'b0;
   logic awr, wr_rdy, bv, arr, rv;
   logic [7:0] awa = '0, ara = '0;
   logic [31:0] wd = '0, rdat, d;
   logic [1:0] bresp, rresp, r;
   logic [15:0] sa = '0, sb = '0, oa, ob;
   int n_fail = 0, samples_checked = 0, n;
   // Unmapped reads return SLVERR with no data worth checking
   iqpc_row_t rows[15] = '{'{0, 8'h3c, 32'h400, RESP_OKAY}, '{0, 8'h40, 32'h0, RESP_OKAY},
      '{0, 8'h30, 32'h400, RESP_OKAY}, '{0, 8'h34, 32'h400, RESP_OKAY},
      '{0, 8'h78, 32'h0, RESP_OKAY}, '{0, 8'h44, 32'h0, RESP_OKAY},
      '{1, 8'h44, 32'h1234, RESP_OKAY}, '{0, 8'h44, 32'h0, RESP_OKAY},
      '{1, 8'hfc, 32'h1, RESP_SLVERR}, '{0, 8'hfc, 32'h0, RESP_SLVERR},
      '{1, 8'h80, 32'h5, RESP_SLVERR}, '{0, 8'h80, 32'h0, RESP_OKAY},
      '{1, 8'h3c, 32'hc000, RESP_OKAY}, '{0, 8'h3c, 32'hc000, RESP_OKAY},
      '{1, 8'h3c, 32'h0, RESP_OKAY}};
   iqpc_top uut(.aclk(aclk), .aresetn(aresetn), .ce(ce), .s_axi_awaddr(awa),
      .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
      .s_axi_wvalid(wv), .s_axi_wready(wr_rdy), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
      .s_axi_bready(brdy), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
      .s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rrdy),
      .sample_a(sa), .sample_b(sb), .out_a(oa), .out_b(ob));
   initial begin
      aclk = 1'b0;
      forever #2 aclk = ~aclk;
   end
   task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
      @(posedge aclk);
      awa <= a;
      wd <= v;
      awv <= 1'b1;
      wv <= 1'b1;
      brdy <= 1'b1;
      do begin
         @(posedge aclk);
         if (awr) awv <= 1'b0;
         if (wr_rdy) wv <= 1'b0;
      end while (!bv);
      rs = bresp;
      brdy <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
      @(posedge aclk);
      ara <= a;
      arv <= 1'b1;
      rrdy <= 1'b1;
      do begin
         @(posedge aclk);
         if (arr) arv <= 1'b0;
      end while (!rv);
      v = rdat;
      rs = rresp;
      rrdy <= 1'b0;
   endtask
   task automatic wchk(input logic [7:0] a, input logic [31:0] v);
      logic [1:0] rs;
      wr(a, v, rs);
      `CHK("write resp", RESP_OKAY, rs)
   endtask
   task automatic settle(input logic [15:0] ea, input logic [15:0] eb);
      repeat (8) @(posedge aclk);
      `CHK("out_a", ea, oa)
      `CHK("out_b", eb, ob)
   endtask
   task report_and_stop;
      $display("Comparisons %0d, mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial begin
      repeat (5000) @(posedge aclk);
      n_fail++;
      report_and_stop;
   end
   initial begin
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      foreach (rows[i]) begin
         if (rows[i].w) begin
            wr(rows[i].a, rows[i].d, r);
         end else begin
            rd(rows[i].a, d, r);
            if (r === RESP_OKAY) `CHK("read data", rows[i].d, d)
         end
         `CHK("resp", rows[i].r, r)
      end
      $display("Register table test done");
      for (int dl = 0; dl < 4; dl++) begin
         wchk(8'h3c, {16'h0, dl[1:0], 14'h0});
         sa <= 16'h0000;
         sb <= 16'h0000;
         repeat (8) @(posedge aclk);
         sa <= 16'h1234;
         sb <= 16'h0567;
         n = 0;
         do begin
            @(posedge aclk);
            n++;
            @(negedge aclk);
         end while (oa !== 16'h1234 && n < 20);
         `CHK("latency", 3 + dl, n)
         `CHK("out_b", 16'h0567, ob)
      end
      wchk(8'h3c, 32'h0);
      $display("Delay test done");
      sa <= 16'h1000;
      sb <= 16'h1000;
      wchk(8'h30, 32'h200);
      wchk(8'h40, 32'h3c00);
      settle(16'h1000, 16'h1000);
      rd(8'h80, d, r);
      `CHK("active phase", 32'h0, d)
      wchk(8'h78, 32'h1);
      wchk(8'h34, 32'h200);
      settle(16'h1000, 16'h1000);
      wchk(8'h40, 32'h3c00);
      // Negative phase catches an unsigned product; new gain b catches a stale commit
      settle(16'h0600, 16'h0800);
      rd(8'h80, d, r);
      `CHK("active phase", 32'h0c00, d)
      $display("Commit test done");
      ce <= 1'b0;
      sa <= 16'h2000;
      repeat (8) @(posedge aclk);
      `CHK("frozen out_a", 16'h0600, oa)
      `CHK("frozen out_b", 16'h0800, ob)
      ce <= 1'b1;
      settle(16'h0e00, 16'h0800);
      sa <= 16'h1000;
      $display("Clock enable test done");
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      settle(16'h1000, 16'h1000);
      rd(8'h40, d, r);
      `CHK("phase reset", 32'h0, d)
      rd(8'h3c, d, r);
      `CHK("latency reset", 32'h400, d)
      $display("Reset test done");
      report_and_stop;
   end
endmodule
bind iqpc_top iqpc_chk chk(.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .out_a(out_a));

// ===== iqpc_chk.sv
/*
 * Checker for the register bus handshakes and reset state of iqpc_top.
 * Assumes it is bound to iqpc_top and that the bus is idle while ce is low.
 */
`timescale 1ns/1ns
module iqpc_chk
   import iqpc_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [DATA_W-1:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [SAMPLE_W-1:0] out_a
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write answer missing");
   a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
      && $stable(s_axi_bresp)) else $error("write answer dropped");
   a_bvalid_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write answer repeated");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
      else $error("read answer missing");
   a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
      && $stable(s_axi_rdata)) else $error("read answer dropped");
   a_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while answer pending");
   a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while answer pending");
   a_reset_clear: assert property ($rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid
      && out_a == 16'h0000) else $error("state not cleared by reset");
   cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
   cover property (s_axi_rvalid && s_axi_rready);
   cover property (out_a == 16'h0600);
endmodule

// ===== iqpc_delay.sv
/*
 * Programmable delay line of zero to three cycles for both channels,
 * with a registered output.
 * Assumes the select is stable or that a glitch of one sample is tolerable.
 */
`timescale 1ns/1ns
module iqpc_delay
   import iqpc_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic [DELAY_W-1:0] sel,
   input wire logic [SAMPLE_W-1:0] in_a,
   input wire logic [SAMPLE_W-1:0] in_b,
   output logic [SAMPLE_W-1:0] out_a,
   output logic [SAMPLE_W-1:0] out_b
);

   logic [SAMPLE_W-1:0] tap_a_q [0:DELAY_MAX];
   logic [SAMPLE_W-1:0] tap_b_q [0:DELAY_MAX];

   always_comb begin
      tap_a_q[0] = in_a;
      tap_b_q[0] = in_b;
   end

   genvar i;
   generate
      for (i = 1; i <= DELAY_MAX; i++) begin : g_tap
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               tap_a_q[i] <= '0;
               tap_b_q[i] <= '0;
            end else if (ce) begin
               tap_a_q[i] <= tap_a_q[i-1];
               tap_b_q[i] <= tap_b_q[i-1];
            end
         end
      end
   endgenerate

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         out_a <= '0;
         out_b <= '0;
      end else if (ce) begin
         out_a <= tap_a_q[sel]; // R1
         out_b <= tap_b_q[sel]; // R1
      end
   end

endmodule

// ===== iqpc_pkg.sv
/*
 * Shared constants for the IQ phase-correction and output-delay block:
 * register indices, field positions, reset values and bus answers.
 * Assumes a 32-bit AXI4-Lite register bus with word-aligned registers.
 */
package iqpc_pkg;

   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int REG_W = 16;
   localparam int SAMPLE_W = 16;
   localparam int IDX_W = 6;

   // Register indices; the byte address is four times the index
   localparam logic [IDX_W-1:0] IDX_GAIN_A = 6'h0c;
   localparam logic [IDX_W-1:0] IDX_GAIN_B = 6'h0d;
   localparam logic [IDX_W-1:0] IDX_LATENCY = 6'h0f;
   localparam logic [IDX_W-1:0] IDX_PHASE = 6'h10;
   localparam logic [IDX_W-1:0] IDX_RSVD = 6'h11;
   localparam logic [IDX_W-1:0] IDX_AUTOSYNC = 6'h1e;
   localparam logic [IDX_W-1:0] IDX_STATUS = 6'h20;
   localparam int IDX_LSB = 2;

   localparam logic [REG_W-1:0] RST_LATENCY = 16'h0400;
   localparam logic [REG_W-1:0] RST_PHASE = 16'h0000;
   localparam logic [REG_W-1:0] RST_GAIN = 16'h0400;
   localparam logic [REG_W-1:0] RST_AUTOSYNC = 16'h0000;

   localparam int DELAY_MSB = 15;
   localparam int DELAY_LSB = 14;
   localparam int DELAY_W = 2;
   localparam int DELAY_MAX = 3;
   localparam int PHASE_MSB = 11;
   localparam int PHASE_W = 12;
   localparam int PHASE_FRAC = 12;
   localparam int GAIN_MSB = 10;
   localparam int GAIN_W = 11;
   localparam int GAIN_FRAC = 10;
   localparam int AUTOSYNC_BIT = 0;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [2:0] {
      SEL_LATENCY = 3'b000,
      SEL_PHASE = 3'b001,
      SEL_RSVD = 3'b010,
      SEL_GAIN_A = 3'b011,
      SEL_GAIN_B = 3'b100,
      SEL_AUTOSYNC = 3'b101,
      SEL_STATUS = 3'b110,
      SEL_NONE = 3'b111
   } iqpc_sel_t;

endpackage

// ===== iqpc_top.sv
/*
 * IQ phase-correction and output-delay register slice with its datapath:
 * AXI4-Lite register file, shadowed gains and phase, correction and delay.
 * Assumes samples arrive every enabled cycle from logic on aclk.
 */
// Notes on behaviour
// R1: Outputs delayed zero to three cycles, reset zero
// R2: Software sets phase register bits 13 and 12
// R3: Phase word is signed fraction, reset zero
// R4: Committed phase times B sample added into A
// R5: Phase write with auto-sync enabled triggers sync
// R6: Sync commits both gains and phase together
// R7: Gain writes alone leave active settings unchanged
// R8: Software writes phase register after gain registers
// R9: Gains are unsigned, ten fractional bits
`timescale 1ns/1ns
module iqpc_top
   import iqpc_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [DATA_W-1:0] s_axi_wdata,
   input wire logic [DATA_W/8-1:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [DATA_W-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [SAMPLE_W-1:0] sample_a,
   input wire logic [SAMPLE_W-1:0] sample_b,
   output logic [SAMPLE_W-1:0] out_a,
   output logic [SAMPLE_W-1:0] out_b
);

   localparam int GPROD_W = SAMPLE_W + GAIN_W + 1;
   localparam int GSCL_W = GPROD_W - GAIN_FRAC;
   localparam int PPROD_W = GSCL_W + PHASE_W;
   localparam int SUM_W = GSCL_W + 1;
   localparam logic signed [SUM_W-1:0] SAT_MAX = SUM_W'(2 ** (SAMPLE_W - 1) - 1);
   localparam logic signed [SUM_W-1:0] SAT_MIN = -SUM_W'(2 ** (SAMPLE_W - 1));

   function automatic iqpc_sel_t decode(input logic [ADDR_W-1:0] addr);
      logic [IDX_W-1:0] idx;
      idx = addr[ADDR_W-1:IDX_LSB];
      if (idx == IDX_LATENCY) begin
         decode = SEL_LATENCY;
      end else if (idx == IDX_PHASE) begin
         decode = SEL_PHASE;
      end else if (idx == IDX_RSVD) begin
         decode = SEL_RSVD;
      end else if (idx == IDX_GAIN_A) begin
         decode = SEL_GAIN_A;
      end else if (idx == IDX_GAIN_B) begin
         decode = SEL_GAIN_B;
      end else if (idx == IDX_AUTOSYNC) begin
         decode = SEL_AUTOSYNC;
      end else if (idx == IDX_STATUS) begin
         decode = SEL_STATUS;
      end else begin
         decode = SEL_NONE;
      end
   endfunction

   function automatic logic [REG_W-1:0] merge(input logic [REG_W-1:0] old,
                                              input logic [DATA_W-1:0] data,
                                              input logic [DATA_W/8-1:0] strb);
      logic [REG_W-1:0] res;
      res = old;
      for (int b = 0; b < REG_W / 8; b++) begin
         if (strb[b]) begin
            res[b*8 +: 8] = data[b*8 +: 8];
         end
      end
      merge = res;
   endfunction

   // Saturate, since a wrapped sample would be a full-scale glitch
   function automatic logic signed [SUM_W-1:0] clip(input logic signed [SUM_W-1:0] v);
      if (v > SAT_MAX) begin
         clip = SAT_MAX;
      end else if (v < SAT_MIN) begin
         clip = SAT_MIN;
      end else begin
         clip = v;
      end
   endfunction

   logic [REG_W-1:0] latency_q;
   logic [REG_W-1:0] phase_q;
   logic [REG_W-1:0] gain_a_q;
   logic [REG_W-1:0] gain_b_q;
   logic [REG_W-1:0] autosync_q;
   logic [GAIN_W-1:0] act_gain_a_q;
   logic [GAIN_W-1:0] act_gain_b_q;
   logic [PHASE_W-1:0] act_phase_q;
   logic [ADDR_W-1:0] waddr_q;
   logic [DATA_W-1:0] wdata_q;
   logic [DATA_W/8-1:0] wstrb_q;
   logic aw_have_q;
   logic w_have_q;
   logic do_write;
   iqpc_sel_t wsel;
   logic sync_now;
   logic [REG_W-1:0] phase_new;

   assign do_write = aw_have_q && w_have_q && !s_axi_bvalid;
   assign wsel = decode(waddr_q);
   assign phase_new = merge(phase_q, wdata_q, wstrb_q);
   assign sync_now = do_write && wsel == SEL_PHASE && autosync_q[AUTOSYNC_BIT]; // R5

   // Address and data are taken independently; one write in flight
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         aw_have_q <= 1'b0;
         waddr_q <= '0;
      end else if (ce) begin
         if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awready <= 1'b0;
            aw_have_q <= 1'b1;
            waddr_q <= s_axi_awaddr;
         end else if (do_write) begin
            aw_have_q <= 1'b0;
         end else if (!aw_have_q && !s_axi_bvalid) begin
            s_axi_awready <= 1'b1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_wready <= 1'b0;
         w_have_q <= 1'b0;
         wdata_q <= '0;
         wstrb_q <= '0;
      end else if (ce) begin
         if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wready <= 1'b0;
            w_have_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end else if (do_write) begin
            w_have_q <= 1'b0;
         end else if (!w_have_q && !s_axi_bvalid) begin
            s_axi_wready <= 1'b1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else if (ce) begin
         if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (wsel == SEL_NONE || wsel == SEL_STATUS) ? RESP_SLVERR : RESP_OKAY;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Holding registers; bits 13:12 of the phase register are plain storage
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         latency_q <= RST_LATENCY; // R1
      end else if (ce && do_write && wsel == SEL_LATENCY) begin
         latency_q <= merge(latency_q, wdata_q, wstrb_q); // R1
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         phase_q <= RST_PHASE; // R3
      end else if (ce && do_write && wsel == SEL_PHASE) begin
         phase_q <= phase_new; // R2
      end
   end

   // Gains reach the datapath only through the commit below
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         gain_a_q <= RST_GAIN;
      end else if (ce && do_write && wsel == SEL_GAIN_A) begin
         gain_a_q <= merge(gain_a_q, wdata_q, wstrb_q); // R7
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         gain_b_q <= RST_GAIN;
      end else if (ce && do_write && wsel == SEL_GAIN_B) begin
         gain_b_q <= merge(gain_b_q, wdata_q, wstrb_q); // R7
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         autosync_q <= RST_AUTOSYNC;
      end else if (ce && do_write && wsel == SEL_AUTOSYNC) begin
         autosync_q <= merge(autosync_q, wdata_q, wstrb_q);
      end
   end

   // Commit takes the new phase word from the bus, not the old holding value
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         act_gain_a_q <= RST_GAIN[GAIN_MSB:0];
         act_gain_b_q <= RST_GAIN[GAIN_MSB:0];
         act_phase_q <= RST_PHASE[PHASE_MSB:0];
      end else if (ce && sync_now) begin
         act_gain_a_q <= gain_a_q[GAIN_MSB:0]; // R6
         act_gain_b_q <= gain_b_q[GAIN_MSB:0]; // R6
         act_phase_q <= phase_new[PHASE_MSB:0]; // R6
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= RESP_OKAY;
      end else if (ce) begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= RESP_OKAY;
            case (decode(s_axi_araddr))
               SEL_LATENCY: s_axi_rdata <= {16'h0000, latency_q};
               SEL_PHASE: s_axi_rdata <= {16'h0000, phase_q};
               SEL_GAIN_A: s_axi_rdata <= {16'h0000, gain_a_q};
               SEL_GAIN_B: s_axi_rdata <= {16'h0000, gain_b_q};
               SEL_AUTOSYNC: s_axi_rdata <= {16'h0000, autosync_q};
               SEL_STATUS: s_axi_rdata <= {20'h00000, act_phase_q};
               SEL_RSVD: s_axi_rdata <= '0;
               default: begin
                  s_axi_rdata <= '0;
                  s_axi_rresp <= RESP_SLVERR;
               end
            endcase
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end else if (!s_axi_rvalid) begin
            s_axi_arready <= 1'b1;
         end
      end
   end

   // Datapath: gain stage, then phase term and saturation
   logic signed [GPROD_W-1:0] prod_a;
   logic signed [GPROD_W-1:0] prod_b;
   logic signed [GSCL_W-1:0] gain_out_a_q;
   logic signed [GSCL_W-1:0] gain_out_b_q;
   logic signed [PPROD_W-1:0] prod_p;
   logic signed [SUM_W-1:0] sum_a;
   logic [SAMPLE_W-1:0] corr_a_q;
   logic [SAMPLE_W-1:0] corr_b_q;

   // Operands widened first so the products keep every bit
   assign prod_a = GPROD_W'($signed(sample_a)) *
                   GPROD_W'($signed({1'b0, act_gain_a_q})); // R9
   assign prod_b = GPROD_W'($signed(sample_b)) *
                   GPROD_W'($signed({1'b0, act_gain_b_q})); // R9
   assign prod_p = PPROD_W'(gain_out_b_q) *
                   PPROD_W'($signed(act_phase_q)); // R3
   assign sum_a = SUM_W'(gain_out_a_q) + SUM_W'(prod_p >>> PHASE_FRAC); // R4

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         gain_out_a_q <= '0;
         gain_out_b_q <= '0;
         corr_a_q <= '0;
         corr_b_q <= '0;
      end else if (ce) begin
         gain_out_a_q <= GSCL_W'(prod_a >>> GAIN_FRAC);
         gain_out_b_q <= GSCL_W'(prod_b >>> GAIN_FRAC);
         corr_a_q <= SAMPLE_W'(clip(sum_a)); // R4
         corr_b_q <= SAMPLE_W'(clip(SUM_W'(gain_out_b_q)));
      end
   end

   iqpc_delay u_delay (
      .aclk(aclk),
      .aresetn(aresetn),
      .ce(ce),
      .sel(latency_q[DELAY_MSB:DELAY_LSB]), // R1
      .in_a(corr_a_q),
      .in_b(corr_b_q),
      .out_a(out_a),
      .out_b(out_b)
   );

endmodule
